/* core/rcl_seq.sv */
// Reset configuration load sequencer: default image, updates, OTP and
// EEPROM configuration, hotfix, ordered completion, power gating.
// Assumes OTP, EEPROM and image engines answer on core_clk with done pulses.
//
// Notes on behaviour
// - Build all-default image, outputs untouched
// - Port protocol from strap; SPI defaults 4-wire
// - Found update applied, restart whole sequence
// - Missing or bad OTP config skips to EEPROM
// - Report OTP errors or loaded config number
// - Config overwrites only listed registers
// - Config data must write every trigger register
// - Programmed PLL divider starts parallel calibration
// - After OTP load, port protocol from image
// - EEPROM block loaded only with good checksum
// - EEPROM search ends at range end or success
// - OTP hotfix run after configuration searches
// - Any config loaded: recalibrate PLL first
// - Ports, commit and outputs, monitors, alarms
// - No config: defaults, failures in status
// - Default lowest power state allowing boot
// - Power only boot blocks and functions marked needed
// - Strap pins captured at reset rising edge
// - Probe addresses 50h-57h at three rates
// - Config blocks at offsets 0000h and F000h
`timescale 1ns/1ps
module rcl_seq #(
  parameter int                PWR_W     = 8,
  parameter logic [PWR_W-1:0] BOOT_MASK = 8'h01
) (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  // Pins
  input  wire logic                        master_reset_n,
  input  wire logic [rcl_pkg::STRAP_W-1:0] strap_pins,
  // Register image engine
  output logic                             img_init_q,
  input  wire logic                        img_init_done,
  input  wire logic                        img_spi_sel,
  input  wire logic                        img_spi_4wire,
  input  wire logic                        img_pll_fb_prog,
  output logic                             img_commit_q,
  // OTP loader
  output logic                             otp_req_q,
  output logic                             otp_op_q,
  output logic [rcl_pkg::CFG_W-1:0]        otp_cfg_q,
  input  wire logic                        otp_done,
  input  wire logic                        otp_found,
  input  wire logic                        otp_crc_ok,
  input  wire logic                        otp_has_hotfix,
  // EEPROM loader
  output logic                             eep_req_q,
  output logic [1:0]                       eep_op_q,
  output logic [6:0]                       eep_addr_q,
  output logic [1:0]                       eep_rate_q,
  output logic [15:0]                      eep_ofs_q,
  input  wire logic                        eep_done,
  input  wire logic                        eep_ack,
  input  wire logic                        eep_valid,
  // System PLL
  output logic                             pll_cal_q,
  input  wire logic                        pll_cal_done,
  // Completion enables
  output logic                             ser_spi_q,
  output logic                             ser_4wire_q,
  output logic                             ser_en_q,
  output logic                             out_en_q,
  output logic                             mon_en_q,
  output logic                             alarm_en_q,
  output logic                             seq_done_q,
  // Status
  output logic [1:0]                       otp_err_q,
  output logic                             otp_loaded_q,
  output logic [rcl_pkg::CFG_W-1:0]        cfg_num_q,
  output logic                             eep_loaded_q,
  output logic                             eep_absent_q,
  output logic                             eep_bad_q,
  output logic                             upd_applied_q,
  // Power control
  input  wire logic [PWR_W-1:0]            pwr_need,
  output logic      [PWR_W-1:0]            pwr_on_q,
  output logic      [PWR_W-1:0]            clk_en_q
);
  import rcl_pkg::*;

  logic [STRAP_W:0]   pins_s;
  logic               mr_prev_q;
  logic               mr_rise;
  logic               mr_low;
  logic [STRAP_W-1:0] strap_q;
  rcl_state_t         state_q;
  logic [2:0]         idx_q;
  logic [1:0]         rate_q;
  logic               ofs_hi_q;
  logic [7:0]         present_q;
  logic               any_loaded;
  logic               otp_ok;
  logic               busy;

  rcl_sync #(
    .W (STRAP_W + 1)
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in ({master_reset_n, strap_pins}),
    .sync_out (pins_s)
  );

  assign mr_low     = ~pins_s[STRAP_W];
  assign mr_rise    = pins_s[STRAP_W] & ~mr_prev_q;
  assign otp_ok     = otp_found & otp_crc_ok;
  assign any_loaded = otp_loaded_q | eep_loaded_q;
  assign busy       = (state_q != S_IDLE) && (state_q != S_RUN);

  // Strap capture
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mr_prev_q <= 1'b0;
      strap_q   <= '0;
    end else begin
      mr_prev_q <= pins_s[STRAP_W];
      if (mr_rise) begin
        strap_q <= pins_s[STRAP_W-1:0];
      end
    end
  end

  // Sequencer and loader requests
  always_ff @(posedge core_clk) begin
    if (sys_rst || mr_low) begin
      state_q    <= S_IDLE;
      img_init_q <= 1'b0;
      otp_req_q  <= 1'b0;
      otp_op_q   <= OOP_CONFIG;
      eep_req_q  <= 1'b0;
      eep_op_q   <= EOP_PROBE;
      idx_q      <= '0;
      rate_q     <= RATE_1M;
      ofs_hi_q   <= 1'b0;
      present_q  <= '0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (mr_rise) begin
            state_q <= S_INIT;
          end
        end
        S_INIT: begin
          if (!img_init_q) begin
            img_init_q <= 1'b1;
          end else if (img_init_done) begin
            img_init_q <= 1'b0;
            idx_q      <= '0;
            rate_q     <= RATE_1M;
            present_q  <= '0;
            if (strap_q[STRAP_UPD] || strap_q[STRAP_EEP]) begin
              state_q <= S_PROBE;
            end else begin
              state_q <= S_OTP;
            end
          end
        end
        S_PROBE: begin
          if (!eep_req_q) begin
            eep_req_q <= 1'b1;
            eep_op_q  <= EOP_PROBE;
          end else if (eep_done) begin
            eep_req_q         <= 1'b0;
            present_q[idx_q] <= eep_ack;
            idx_q             <= idx_q + 3'h1;
            if (idx_q == EEP_LAST_IDX) begin
              if ((present_q != 8'h00) || eep_ack
                  || (rate_q == RATE_100K)) begin
                state_q <= strap_q[STRAP_UPD] ? S_UPD : S_OTP;
              end else begin
                rate_q <= rate_q + 2'h1;
              end
            end
          end
        end
        S_UPD: begin
          if (!present_q[idx_q]) begin
            idx_q <= idx_q + 3'h1;
            if (idx_q == EEP_LAST_IDX) begin
              state_q <= S_OTP;
            end
          end else if (!eep_req_q) begin
            eep_req_q <= 1'b1;
            eep_op_q  <= EOP_UPDATE;
          end else if (eep_done) begin
            eep_req_q <= 1'b0;
            idx_q     <= idx_q + 3'h1;
            if (eep_valid) begin
              state_q <= S_INIT;
            end else if (idx_q == EEP_LAST_IDX) begin
              state_q <= S_OTP;
            end
          end
        end
        S_OTP: begin
          if (!otp_req_q) begin
            otp_req_q <= 1'b1;
            otp_op_q  <= OOP_CONFIG;
          end else if (otp_done) begin
            otp_req_q <= 1'b0;
            idx_q     <= '0;
            ofs_hi_q  <= 1'b0;
            state_q   <= strap_q[STRAP_EEP] ? S_ECFG : S_HOTFIX;
          end
        end
        S_ECFG: begin
          if (!present_q[idx_q]) begin
            idx_q <= idx_q + 3'h1;
            if (idx_q == EEP_LAST_IDX) begin
              state_q <= S_HOTFIX;
            end
          end else if (!eep_req_q) begin
            eep_req_q <= 1'b1;
            eep_op_q  <= EOP_CONFIG;
          end else if (eep_done) begin
            eep_req_q <= 1'b0;
            ofs_hi_q  <= ~ofs_hi_q;
            if (ofs_hi_q) begin
              idx_q <= idx_q + 3'h1;
            end
            if (eep_valid || (ofs_hi_q && idx_q == EEP_LAST_IDX)) begin
              state_q <= S_HOTFIX;
            end
          end
        end
        S_HOTFIX: begin
          if (!otp_has_hotfix) begin
            state_q <= S_PLL;
          end else if (!otp_req_q) begin
            otp_req_q <= 1'b1;
            otp_op_q  <= OOP_HOTFIX;
          end else if (otp_done) begin
            otp_req_q <= 1'b0;
            state_q   <= S_PLL;
          end
        end
        S_PLL: begin
          if (!any_loaded || (pll_cal_q && pll_cal_done)) begin
            state_q <= S_SER;
          end
        end
        S_SER: state_q <= S_COMMIT;
        S_COMMIT: state_q <= S_MON;
        S_MON: state_q <= S_ALARM;
        S_ALARM: state_q <= S_RUN;
        S_RUN: state_q <= S_RUN;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Loader addressing
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      eep_addr_q <= EEP_BASE_ADDR;
      eep_rate_q <= RATE_1M;
      eep_ofs_q  <= EEP_OFS_LOW;
      otp_cfg_q  <= '0;
    end else begin
      eep_addr_q <= EEP_BASE_ADDR | {4'h0, idx_q};
      eep_rate_q <= rate_q;
      eep_ofs_q  <= ofs_hi_q ? EEP_OFS_HIGH : EEP_OFS_LOW;
      otp_cfg_q  <= strap_q[STRAP_CFG_LO +: CFG_W];
    end
  end

  // Load status; the loaders overlay only listed registers
  always_ff @(posedge core_clk) begin
    if (sys_rst || mr_low || (state_q == S_IDLE && mr_rise)) begin
      otp_err_q     <= 2'h0;
      otp_loaded_q  <= 1'b0;
      cfg_num_q     <= '0;
      eep_loaded_q  <= 1'b0;
      eep_absent_q  <= 1'b0;
      eep_bad_q     <= 1'b0;
      upd_applied_q <= 1'b0;
    end else begin
      if (state_q == S_OTP && otp_req_q && otp_done) begin
        otp_err_q    <= {otp_found & ~otp_crc_ok, ~otp_found};
        otp_loaded_q <= otp_ok;
        if (otp_ok) begin
          cfg_num_q <= otp_cfg_q;
        end
      end
      if (state_q == S_PROBE && eep_req_q && eep_done
          && idx_q == EEP_LAST_IDX && rate_q == RATE_100K
          && present_q == 8'h00 && !eep_ack) begin
        eep_absent_q <= 1'b1;
      end
      if (state_q == S_ECFG && eep_req_q && eep_done) begin
        if (eep_valid) begin
          eep_loaded_q <= 1'b1;
        end else begin
          eep_bad_q <= 1'b1;
        end
      end
      if (state_q == S_UPD && eep_req_q && eep_done && eep_valid) begin
        upd_applied_q <= 1'b1;
      end
    end
  end

  // Serial port setup and PLL calibration
  always_ff @(posedge core_clk) begin
    if (sys_rst || mr_low) begin
      ser_spi_q   <= 1'b0;
      ser_4wire_q <= 1'b0;
      pll_cal_q   <= 1'b0;
    end else begin
      if (state_q == S_INIT) begin
        ser_spi_q   <= strap_q[STRAP_PROTO];
        ser_4wire_q <= strap_q[STRAP_PROTO];
      end
      if (state_q == S_OTP && otp_req_q && otp_done && otp_ok) begin
        ser_spi_q   <= img_spi_sel;
        ser_4wire_q <= img_spi_4wire;
      end
      if ((state_q == S_OTP && otp_req_q && otp_done && otp_ok
           && img_pll_fb_prog)
          || (state_q == S_PLL && any_loaded && !pll_cal_q)) begin
        pll_cal_q <= 1'b1;
      end else if (pll_cal_done) begin
        pll_cal_q <= 1'b0;
      end
    end
  end

  // Completion enables in order
  always_ff @(posedge core_clk) begin
    if (sys_rst || mr_low || state_q == S_INIT) begin
      ser_en_q     <= 1'b0;
      img_commit_q <= 1'b0;
      out_en_q     <= 1'b0;
      mon_en_q     <= 1'b0;
      alarm_en_q   <= 1'b0;
      seq_done_q   <= 1'b0;
    end else begin
      img_commit_q <= (state_q == S_COMMIT);
      if (state_q == S_SER) begin
        ser_en_q <= 1'b1;
      end
      if (state_q == S_COMMIT) begin
        out_en_q <= 1'b1;
      end
      if (state_q == S_MON) begin
        mon_en_q <= 1'b1;
      end
      if (state_q == S_ALARM) begin
        alarm_en_q <= 1'b1;
        seq_done_q <= 1'b1;
      end
    end
  end

  // Power: boot blocks powered, clocked only while booting
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pwr_on_q <= BOOT_MASK;
      clk_en_q <= BOOT_MASK;
    end else begin
      pwr_on_q <= pwr_need | BOOT_MASK;
      clk_en_q <= pwr_need | (BOOT_MASK & {PWR_W{busy}});
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst || mr_low);

  sequence s_otp_end;
    state_q == S_OTP && otp_req_q && otp_done;
  endsequence
  sequence s_ecfg_hit;
    state_q == S_ECFG && eep_req_q && eep_done && eep_valid;
  endsequence

  property p_strap;
    mr_rise |=> strap_q == $past(pins_s[STRAP_W-1:0]);
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap not captured at reset release");
  property p_init;
    (state_q == S_IDLE && mr_rise) |=> state_q == S_INIT ##1 img_init_q;
  endproperty
  a_init: assert property (p_init)
    else $error("image init not requested");
  property p_upd_restart;
    (state_q == S_UPD && eep_req_q && eep_done && eep_valid)
      |=> state_q == S_INIT;
  endproperty
  a_upd_restart: assert property (p_upd_restart)
    else $error("update did not restart sequence");
  property p_otp_skip;
    (s_otp_end and (!otp_ok && strap_q[STRAP_EEP])) |=> state_q == S_ECFG;
  endproperty
  a_otp_skip: assert property (p_otp_skip)
    else $error("bad OTP config did not go to EEPROM");
  property p_otp_report;
    (s_otp_end and otp_ok) |=> otp_loaded_q && otp_err_q == 2'h0
      && cfg_num_q == otp_cfg_q;
  endproperty
  a_otp_report: assert property (p_otp_report)
    else $error("OTP load not reported");
  property p_pll_par;
    (s_otp_end and (otp_ok && img_pll_fb_prog)) |=> pll_cal_q
      && state_q != S_OTP;
  endproperty
  a_pll_par: assert property (p_pll_par)
    else $error("PLL calibration not started in parallel");
  property p_ecfg_end;
    s_ecfg_hit |=> state_q == S_HOTFIX && eep_loaded_q;
  endproperty
  a_ecfg_end: assert property (p_ecfg_end)
    else $error("EEPROM search did not end on valid block");
  property p_order;
    $rose(ser_en_q) |=> out_en_q ##1 mon_en_q ##1 alarm_en_q && seq_done_q;
  endproperty
  a_order: assert property (p_order)
    else $error("completion order broken");
  property p_quiet;
    busy |-> !ser_en_q || state_q == S_COMMIT || state_q == S_MON
      || state_q == S_ALARM;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("serial port enabled during load");
  property p_gate;
    (state_q == S_RUN && pwr_need == '0)[*2] |-> clk_en_q == '0;
  endproperty
  a_gate: assert property (p_gate)
    else $error("unneeded block still clocked");
endmodule

/* core/rcl_pkg.sv */
// Constants shared by the reset configuration load sequencer.
// Assumes one core clock domain; pins are synchronised before use.
package rcl_pkg;
  // Strap pin layout, captured at the master reset rising edge
  localparam int STRAP_W      = 7;
  localparam int STRAP_PROTO  = 0;
  localparam int STRAP_UPD    = 1;
  localparam int STRAP_EEP    = 2;
  localparam int STRAP_CFG_LO = 3;
  localparam int CFG_W        = 4;
  // EEPROM probe range and clock rate codes
  localparam logic [6:0] EEP_BASE_ADDR = 7'h50;
  localparam logic [2:0] EEP_LAST_IDX  = 3'h7;
  localparam logic [1:0] RATE_1M       = 2'h0;
  localparam logic [1:0] RATE_400K     = 2'h1;
  localparam logic [1:0] RATE_100K     = 2'h2;
  // Block offsets inside one EEPROM
  localparam logic [15:0] EEP_OFS_LOW  = 16'h0000;
  localparam logic [15:0] EEP_OFS_HIGH = 16'hF000;
  // Loader operation codes
  localparam logic [1:0] EOP_PROBE  = 2'h0;
  localparam logic [1:0] EOP_UPDATE = 2'h1;
  localparam logic [1:0] EOP_CONFIG = 2'h2;
  localparam logic       OOP_CONFIG = 1'b0;
  localparam logic       OOP_HOTFIX = 1'b1;
  // Sequencer states
  typedef enum logic [12:0] {
    S_IDLE   = 13'h0001,
    S_INIT   = 13'h0002,
    S_PROBE  = 13'h0004,
    S_UPD    = 13'h0008,
    S_OTP    = 13'h0010,
    S_ECFG   = 13'h0020,
    S_HOTFIX = 13'h0040,
    S_PLL    = 13'h0080,
    S_SER    = 13'h0100,
    S_COMMIT = 13'h0200,
    S_MON    = 13'h0400,
    S_ALARM  = 13'h0800,
    S_RUN    = 13'h1000
  } rcl_state_t;
endpackage

/* core/rcl_sync.sv */
// Two flip-flop synchroniser for a group of pin levels.
// Assumes the inputs are levels from outside the core clock domain.
`timescale 1ns/1ps
module rcl_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* sim/rcl_partner.sv */
// Far side model: image engine, OTP, EEPROM loader and system PLL.
// Assumes request/done handshakes sampled on core_clk.
`timescale 1ns/1ps
module rcl_partner (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  // Scenario: found crc spi pll hotfix upd mask slow idx ofs
  input  wire logic [34:0]               knob,
  // Requests
  input  wire logic                      img_init_q,
  input  wire logic                      otp_req_q,
  input  wire logic                      otp_op_q,
  input  wire logic [rcl_pkg::CFG_W-1:0] otp_cfg_q,
  input  wire logic                      eep_req_q,
  input  wire logic [1:0]                eep_op_q,
  input  wire logic [6:0]                eep_addr_q,
  input  wire logic [1:0]                eep_rate_q,
  input  wire logic [15:0]               eep_ofs_q,
  input  wire logic                      pll_cal_q,
  // Answers
  output logic                           img_init_done,
  output logic                           img_spi_sel,
  output logic                           img_spi_4wire,
  output logic                           img_pll_fb_prog,
  output logic                           otp_done,
  output logic                           otp_found,
  output logic                           otp_crc_ok,
  output logic                           otp_has_hotfix,
  output logic                           eep_done,
  output logic                           eep_ack,
  output logic                           eep_valid,
  output logic                           pll_cal_done
);
  import rcl_pkg::*;
  logic [3:0]  req;
  logic [3:0]  done;
  logic [3:0]  cnt [4];
  logic [2:0]  lat;
  logic        tgl;
  logic        hit;
  logic        used;
  logic [2:0]  idx;
  int          n_init;
  int          n_pll;
  logic [26:0] eep_log [$];
  logic [4:0]  otp_log [$];

  assign req = {pll_cal_q, eep_req_q, otp_req_q, img_init_q};
  assign {pll_cal_done, eep_done, otp_done, img_init_done} = done;
  assign idx = eep_addr_q[2:0];
  // Image contents are levels; loader data toggles outside done
  assign img_spi_sel     = knob[2];
  assign img_spi_4wire   = knob[2];
  assign img_pll_fb_prog = knob[3];
  assign otp_has_hotfix  = knob[4];
  assign otp_found       = done[1] ? knob[0] : tgl;
  assign otp_crc_ok      = done[1] ? knob[1] : tgl;
  assign eep_ack         = done[2] ? hit : tgl;
  assign eep_valid       = done[2] ? hit : tgl;

  // EEPROM: presence by rate, one update, one valid block
  always_comb begin
    case (eep_op_q)
      EOP_PROBE:  hit = knob[6 + idx] && eep_rate_q >= knob[15:14];
      EOP_UPDATE: hit = knob[5] && !used;
      EOP_CONFIG: hit = idx == knob[18:16] && eep_ofs_q == knob[34:19];
      default:    hit = 1'b0;
    endcase
  end

  // Done pulse after a latency that varies per request
  always @(posedge core_clk) begin
    tgl <= sys_rst ? 1'b0 : ~tgl;
    for (int i = 0; i < 4; i++) begin
      done[i] <= 1'b0;
      if (sys_rst) begin
        cnt[i] <= 4'h0;
      end else if (req[i] && !done[i]) begin
        if (cnt[i] < {1'b0, lat}) begin
          cnt[i] <= cnt[i] + 4'h1;
        end else begin
          done[i] <= 1'b1;
          cnt[i]  <= 4'h0;
        end
      end
    end
  end

  // Log of served requests
  always @(posedge core_clk) begin
    if (sys_rst) begin
      lat <= 3'h0;
      used <= 1'b0;
      n_init <= 0;
      n_pll <= 0;
      eep_log.delete();
      otp_log.delete();
    end else begin
      if (|done) lat <= (lat == 3'h4) ? 3'h0 : lat + 3'h1;
      if (done[0]) n_init <= n_init + 1;
      if (done[1]) otp_log.push_back({otp_op_q, otp_cfg_q});
      if (done[2]) eep_log.push_back({eep_op_q, eep_addr_q, eep_rate_q,
                                      eep_ofs_q});
      if (done[2] && eep_op_q == EOP_UPDATE && hit) used <= 1'b1;
      if (done[3]) n_pll <= n_pll + 1;
    end
  end
endmodule

/* sim/rcl_seq_tb.sv */
// Testbench for the reset configuration load sequencer.
// Assumes the far side model in rcl_partner.
`timescale 1ns/1ps
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("Error t=%0t got %0h exp %0h", $time, (g), (e)); \
  end \
end
module rcl_seq_tb;
  import rcl_pkg::*;
  localparam logic [7:0] BOOT = 8'h01;
  logic             core_clk, sys_rst, master_reset_n;
  logic [6:0]       strap_pins, eep_addr_q;
  logic             img_init_q, img_init_done, img_spi_sel, img_spi_4wire;
  logic             img_pll_fb_prog, img_commit_q, otp_req_q, otp_op_q;
  logic             otp_done, otp_found, otp_crc_ok, otp_has_hotfix;
  logic             eep_req_q, eep_done, eep_ack, eep_valid;
  logic [CFG_W-1:0] otp_cfg_q, cfg_num_q;
  logic [1:0]       eep_op_q, eep_rate_q, otp_err_q;
  logic [15:0]      eep_ofs_q;
  logic             pll_cal_q, pll_cal_done, ser_spi_q, ser_4wire_q;
  logic             ser_en_q, out_en_q, mon_en_q, alarm_en_q, seq_done_q;
  logic             otp_loaded_q, eep_loaded_q, eep_absent_q, eep_bad_q;
  logic             upd_applied_q;
  logic [7:0]       pwr_need, pwr_on_q, clk_en_q;
  logic [34:0]      knob;
  logic [26:0]      e;
  int               num_errors, total_checks, cyc;
  int               t_ser, t_out, t_mon, t_alm, t_com;

  rcl_seq #(.PWR_W(8), .BOOT_MASK(BOOT)) rcl_seq_i (.*);
  rcl_partner rcl_partner_i (.*);

  always #2.5 core_clk = ~core_clk;

  // Completion timing monitor and run limit
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (ser_en_q && t_ser == 0) t_ser <= cyc;
    if (out_en_q && t_out == 0) t_out <= cyc;
    if (mon_en_q && t_mon == 0) t_mon <= cyc;
    if (alarm_en_q && t_alm == 0) t_alm <= cyc;
    if (img_commit_q && t_com == 0) t_com <= cyc;
    if (cyc == 40000) begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask

  function automatic logic [34:0] kb(input logic f, c, s, p, h, u,
      input logic [7:0] m, input logic [1:0] sl, input logic [2:0] ix,
      input logic [15:0] of);
    return {of, ix, sl, m, u, h, p, s, c, f};
  endfunction

  // Full boot from master reset release to sequence done
  task automatic run(input logic [6:0] st, input logic [34:0] kn);
    int i;
    sys_rst = 1'b1;
    master_reset_n = 1'b0;
    strap_pins = st;
    knob = kn;
    tick(5);
    `CHK(pwr_on_q, BOOT)
    `CHK(ser_en_q, 1'b0)
    sys_rst = 1'b0;
    tick(3);
    {t_ser, t_out, t_mon, t_alm, t_com} = '0;
    master_reset_n = 1'b1;
    tick(6);
    strap_pins = ~st;
    i = 0;
    while (seq_done_q !== 1'b1 && i < 4000) begin
      tick(1);
      i++;
    end
    `CHK(seq_done_q, 1'b1)
    tick(2);
    `CHK(t_out - t_ser, 1)
    `CHK(t_com, t_out)
    `CHK(t_mon - t_out, 1)
    `CHK(t_alm - t_mon, 1)
  endtask

  task automatic chk_sweep(input int n);
    for (int k = 0; k < n; k++) begin
      e = rcl_partner_i.eep_log[k];
      `CHK(e[26:16], {EOP_PROBE, EEP_BASE_ADDR + 7'(k % 8), 2'(k / 8)})
    end
  endtask

  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    master_reset_n = 1'b0;
    strap_pins = '0;
    pwr_need = '0;
    knob = '0;
    {num_errors, total_checks, cyc} = '0;
    // OTP config 5 with hotfix, EEPROM off, image selects I2C
    run({4'h5, 3'b001}, kb(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0,
        8'h00, 2'h0, 3'h0, 16'h1234));
    `CHK(otp_loaded_q, 1'b1)
    `CHK(cfg_num_q, 4'h5)
    `CHK(otp_err_q, 2'h0)
    `CHK(ser_spi_q, 1'b0)
    `CHK(rcl_partner_i.n_init, 1)
    `CHK(rcl_partner_i.otp_log[0], 5'h05)
    `CHK(rcl_partner_i.otp_log[1][4], OOP_HOTFIX)
    `CHK(rcl_partner_i.n_pll, 1)
    `CHK(rcl_partner_i.eep_log.size(), 0)
    // OTP config missing, no EEPROM fitted
    run({4'h2, 3'b101}, kb(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
        8'h00, 2'h0, 3'h0, 16'h1234));
    `CHK(otp_err_q, 2'h1)
    `CHK(otp_loaded_q, 1'b0)
    `CHK(eep_absent_q, 1'b1)
    `CHK(ser_en_q, 1'b1)
    `CHK({ser_spi_q, ser_4wire_q}, 2'h3)
    `CHK(rcl_partner_i.n_pll, 0)
    `CHK(rcl_partner_i.otp_log.size(), 1)
    `CHK(rcl_partner_i.eep_log.size(), 24)
    chk_sweep(24);
    // Bad OTP checksum; EEPROMs 1, 3, 5 answer from 400 kHz down
    run({4'h3, 3'b100}, kb(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
        8'h2A, 2'h1, 3'h3, 16'hF000));
    `CHK(otp_err_q, 2'h2)
    `CHK(eep_loaded_q, 1'b1)
    `CHK(eep_bad_q, 1'b1)
    `CHK(eep_absent_q, 1'b0)
    `CHK(ser_en_q, 1'b1)
    `CHK(rcl_partner_i.n_pll, 1)
    `CHK(rcl_partner_i.eep_log.size(), 20)
    chk_sweep(16);
    for (int k = 0; k < 4; k++) begin
      e = rcl_partner_i.eep_log[16 + k];
      `CHK({e[26:18], e[15:0]}, {EOP_CONFIG, EEP_BASE_ADDR + 7'(1 + 2 * (k / 2)), k[0] ? EEP_OFS_HIGH : EEP_OFS_LOW})
    end
    // Update in EEPROM 0 is applied once and the sequence restarts
    run({4'h1, 3'b111}, kb(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1,
        8'h01, 2'h0, 3'h0, 16'h1234));
    `CHK(upd_applied_q, 1'b1)
    `CHK(rcl_partner_i.n_init, 2)
    `CHK(cfg_num_q, 4'h1)
    `CHK(rcl_partner_i.n_pll != 0, 1'b1)
    e = rcl_partner_i.eep_log[8];
    `CHK(e[26:16], {EOP_UPDATE, EEP_BASE_ADDR, RATE_1M})
    // Functions marked needed are powered, then dropped
    pwr_need = 8'h30;
    tick(4);
    `CHK(pwr_on_q & 8'h30, 8'h30)
    `CHK(clk_en_q & 8'h30, 8'h30)
    pwr_need = 8'h00;
    tick(4);
    `CHK(pwr_on_q & 8'h30, 8'h00)
    results();
  end
endmodule
